//--- design/shm_homing.sv
// homing controller with origin store, wishbone register slave and interrupt
`timescale 1ns/1ps
module shm_homing
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_power_up,
	input wire logic [7:0] i_input_pins,
	input wire logic i_servo_on,
	input wire logic i_position_mode,
	input wire logic i_positioning_complete,
	input wire logic i_forward_overtravel,
	input wire logic i_reverse_overtravel,
	input wire logic i_index_pulse,
	input wire logic [shm_pkg::ST_W-1:0] i_single_turn,
	input wire logic [shm_pkg::MT_W-1:0] i_multi_turn,
	input wire logic i_multiturn_alarm,
	input wire logic i_pos_ref_valid,
	output logic o_position_ref_accept,
	output logic o_move_enable,
	output logic o_move_forward,
	output logic [11:0] o_move_speed,
	output logic o_homing_busy,
	output logic o_homing_done,
	output logic o_limit_state,
	output logic o_warning,
	output logic o_irq
);
	import shm_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0] cfg_q, cfg_d, act_cfg_q, act_cfg_d;
	logic [3:0] mode_q, mode_d, act_mode_q, act_mode_d;
	logic mtu_q, mtu_d;
	logic [11:0] spd_tw_q, spd_tw_d;
	logic [7:0] spd_lv_q, spd_lv_d;
	logic [2:0] pin_st_q, pin_st_d, pin_org_q, pin_org_d;
	logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
	logic [31:0] rdat_q, rdat_d;
	logic ack_q, ack_d;
	shm_state_e state_q, state_d;
	logic dir_q, dir_d, done_q, done_d, valid_q, valid_d;
	logic [ST_W-1:0] org_st_q, org_st_d;
	logic [MT_W-1:0] org_mt_q, org_mt_d;
	logic auto_q, auto_d, booted_q, booted_d;
	logic start_prev_q, servo_prev_q, warn_prev_q;
	logic [11:0] spd_q, spd_d;

	logic boot, start_sw, org_sw, start_rise, start_ok, trig, auto_trig;
	logic act_en, act_auto, act_store, act_limit;
	logic ot_dir, decel_hit, origin_hit, limit_hit, finish;
	logic ev_done, ev_limit, ev_refused, ev_warn;
	logic wr, rd_cycle;
	logic [39:0] pos_diff;
	logic [11:0] wr_tw;
	logic [7:0] wr_lv;

	// ---------------------------------------------------------------
	// input selection and start qualification
	// ---------------------------------------------------------------
	// first edge after reset counts as a power-up as well
	assign boot = i_power_up | ~booted_q;
	assign start_sw = i_input_pins[pin_st_q];
	assign org_sw = i_input_pins[pin_org_q];
	assign start_rise = start_sw & ~start_prev_q;
	assign act_en = act_cfg_q[CFG_EN_BIT];
	assign act_auto = act_cfg_q[CFG_AUTO_BIT];
	assign act_store = act_cfg_q[CFG_STORE_BIT];
	assign act_limit = act_cfg_q[CFG_LIMIT_BIT];
	// every start condition checked together
	assign start_ok = act_en & i_servo_on & i_position_mode & i_positioning_complete
		& ~i_forward_overtravel & ~i_reverse_overtravel;
	assign auto_trig = auto_q & i_servo_on & ~servo_prev_q;
	assign trig = (start_rise | auto_trig) & (state_q == ST_IDLE);

	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	// odd modes search forward, even modes reverse
	always_comb
	begin
		ot_dir = dir_q ? i_forward_overtravel : i_reverse_overtravel;
		decel_hit = 1'b0;
		origin_hit = 1'b0;
		limit_hit = 1'b0;
		unique case (act_mode_q)
			4'h1, 4'h2:
			begin
				decel_hit = org_sw;
				origin_hit = ~org_sw;
				limit_hit = ot_dir;
			end
			4'h3, 4'h4:
			begin
				decel_hit = org_sw;
				origin_hit = i_index_pulse;
				limit_hit = ot_dir;
			end
			4'h5, 4'h6:
			begin
				decel_hit = i_index_pulse;
				origin_hit = i_index_pulse;
				limit_hit = ot_dir;
			end
			4'h7, 4'h8:
			begin
				decel_hit = ot_dir;
				origin_hit = ~i_forward_overtravel & ~i_reverse_overtravel;
			end
			4'h9, 4'hA:
			begin
				decel_hit = ot_dir;
				origin_hit = i_index_pulse;
			end
			default:
			begin
				decel_hit = 1'b0;
				origin_hit = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// homing sequencer and origin store
	// ---------------------------------------------------------------
	// alarm has the last word so a bad multi-turn count never leaves a stale origin
	always_comb
	begin
		state_d = state_q;
		dir_d = dir_q;
		done_d = done_q;
		valid_d = valid_q;
		org_st_d = org_st_q;
		org_mt_d = org_mt_q;
		auto_d = auto_q;
		act_cfg_d = act_cfg_q;
		act_mode_d = act_mode_q;
		spd_d = spd_q;
		finish = 1'b0;
		ev_limit = 1'b0;
		ev_refused = 1'b0;
		if (auto_trig)
			auto_d = 1'b0; // only the first servo-on counts
		unique case (state_q)
			ST_IDLE:
			begin
				if (trig && start_ok)
				begin
					done_d = 1'b0;
					dir_d = act_mode_q[0];
					spd_d = spd_tw_q;
					if (act_mode_q == 4'h0)
						finish = 1'b1;
					else
						state_d = ST_SEEK;
				end
				else if (trig)
					ev_refused = 1'b1; // edge dropped, not held
			end
			ST_SEEK:
			begin
				if (decel_hit)
				begin
					state_d = ST_CREEP;
					dir_d = ~dir_q;
					spd_d = spd_lv_q;
				end
				else if (limit_hit && act_limit)
				begin
					state_d = ST_LIMIT;
					ev_limit = 1'b1;
				end
				else if (limit_hit)
				begin
					state_d = ST_BACKOFF;
					dir_d = ~dir_q;
				end
			end
			ST_BACKOFF:
			begin
				if (!i_forward_overtravel && !i_reverse_overtravel)
					state_d = ST_SEEK;
			end
			ST_CREEP:
			begin
				if (origin_hit)
					finish = 1'b1;
			end
			ST_LIMIT:
			begin
				if (!i_servo_on)
					state_d = ST_IDLE;
			end
		endcase
		// leaving position control or servo off aborts a search
		if (state_q != ST_IDLE && state_q != ST_LIMIT && (!i_position_mode || !i_servo_on))
			state_d = ST_IDLE;
		if (finish)
		begin
			state_d = ST_IDLE;
			done_d = 1'b1;
			if (act_store)
			begin
				org_st_d = i_single_turn;
				org_mt_d = i_multi_turn;
				valid_d = 1'b1;
			end
			else
			begin
				org_st_d = '0;
				org_mt_d = '0;
				valid_d = 1'b0;
			end
		end
		// power-up: new configuration and mode settings go live only here
		if (boot)
		begin
			act_cfg_d = cfg_q;
			act_mode_d = (mode_q > MODE_MAX) ? MODE_RST : mode_q;
			state_d = ST_IDLE;
			auto_d = cfg_q[CFG_EN_BIT] & cfg_q[CFG_AUTO_BIT];
			done_d = cfg_q[CFG_EN_BIT] & cfg_q[CFG_STORE_BIT] & ~mtu_q & valid_q;
			if (!cfg_q[CFG_STORE_BIT])
			begin
				org_st_d = '0;
				org_mt_d = '0;
				valid_d = 1'b0;
			end
		end
		if (i_multiturn_alarm)
		begin
			org_st_d = '0;
			org_mt_d = '0;
			valid_d = 1'b0;
			done_d = 1'b0;
		end
	end
	assign ev_done = finish & ~i_multiturn_alarm;

	// sequencer registers
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_q <= ST_IDLE;
			dir_q <= 1'b0;
			done_q <= 1'b0;
			valid_q <= 1'b0;
			org_st_q <= '0;
			org_mt_q <= '0;
			auto_q <= 1'b0;
			act_cfg_q <= CFG_RST;
			act_mode_q <= MODE_RST;
			spd_q <= SPD_TOWARD_RST;
			booted_q <= 1'b0;
			start_prev_q <= 1'b0;
			servo_prev_q <= 1'b0;
			warn_prev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			dir_q <= dir_d;
			done_q <= done_d;
			valid_q <= valid_d;
			org_st_q <= org_st_d;
			org_mt_q <= org_mt_d;
			auto_q <= auto_d;
			act_cfg_q <= act_cfg_d;
			act_mode_q <= act_mode_d;
			spd_q <= spd_d;
			booted_q <= booted_d;
			start_prev_q <= start_sw;
			servo_prev_q <= i_servo_on;
			warn_prev_q <= o_warning;
		end
	end
	assign booted_d = 1'b1;

	// ---------------------------------------------------------------
	// outputs to the motion path
	// ---------------------------------------------------------------
	assign o_homing_busy = (state_q == ST_SEEK) || (state_q == ST_CREEP) || (state_q == ST_BACKOFF);
	assign o_position_ref_accept = i_pos_ref_valid & ~o_homing_busy;
	assign o_move_enable = o_homing_busy;
	assign o_move_forward = dir_q;
	assign o_move_speed = spd_q;
	assign o_homing_done = done_q;
	assign o_limit_state = (state_q == ST_LIMIT);
	// combinational so the warning follows the origin flag with no lag
	assign o_warning = act_store & ~valid_q;
	assign ev_warn = o_warning & ~warn_prev_q;
	assign pos_diff = {i_multi_turn, i_single_turn} - {org_mt_q, org_st_q};

	// ---------------------------------------------------------------
	// wishbone slave and interrupt
	// ---------------------------------------------------------------
	assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_q;
	assign rd_cycle = i_wb_cyc & i_wb_stb & ~ack_q;
	// speeds are clamped on write so the drive never sees an out-of-range target
	assign wr_tw = (i_wb_dat[11:0] > SPD_TOWARD_MAX) ? SPD_TOWARD_MAX : i_wb_dat[11:0];
	assign wr_lv = (i_wb_dat[SPD_LEAVE_LSB+7:SPD_LEAVE_LSB] > SPD_LEAVE_MAX) ? SPD_LEAVE_MAX
		: i_wb_dat[SPD_LEAVE_LSB+7:SPD_LEAVE_LSB];
	always_comb
	begin
		cfg_d = cfg_q;
		mode_d = mode_q;
		mtu_d = mtu_q;
		spd_tw_d = spd_tw_q;
		spd_lv_d = spd_lv_q;
		pin_st_d = pin_st_q;
		pin_org_d = pin_org_q;
		irq_mask_d = irq_mask_q;
		irq_st_d = irq_st_q;
		rdat_d = rdat_q;
		ack_d = rd_cycle;
		if (wr)
		begin
			unique case (i_wb_adr)
				ADDR_CFG:
				begin
					if (i_wb_sel[0])
						cfg_d[7:0] = i_wb_dat[7:0];
					if (i_wb_sel[1])
						cfg_d[15:8] = i_wb_dat[15:8];
				end
				ADDR_MODE: if (i_wb_sel[0]) mode_d = i_wb_dat[3:0];
				ADDR_SPEED:
				begin
					if (i_wb_sel[0] && i_wb_sel[1])
						spd_tw_d = wr_tw;
					if (i_wb_sel[2])
						spd_lv_d = wr_lv;
				end
				ADDR_PINSEL:
				begin
					if (i_wb_sel[0])
					begin
						pin_st_d = i_wb_dat[2:0];
						pin_org_d = i_wb_dat[PIN_ORG_LSB+2:PIN_ORG_LSB];
					end
				end
				ADDR_IRQ_ST: if (i_wb_sel[0]) irq_st_d = irq_st_q & ~i_wb_dat[IRQ_W-1:0];
				ADDR_IRQ_MASK: if (i_wb_sel[0]) irq_mask_d = i_wb_dat[IRQ_W-1:0];
				ADDR_ENC_CFG: if (i_wb_sel[0]) mtu_d = i_wb_dat[0];
				default: irq_st_d = irq_st_q;
			endcase
		end
		// set wins over a clear in the same cycle
		irq_st_d = irq_st_d | {ev_refused, ev_warn, ev_limit, ev_done};
		rdat_d = 32'h0000_0000;
		unique case (i_wb_adr)
			ADDR_CFG: rdat_d[15:0] = cfg_q;
			ADDR_MODE: rdat_d[3:0] = mode_q;
			ADDR_SPEED: rdat_d = {8'h00, spd_lv_q, 4'h0, spd_tw_q};
			ADDR_PINSEL: rdat_d[7:0] = {1'b0, pin_org_q, 1'b0, pin_st_q};
			ADDR_ORG_ST: rdat_d[ST_W-1:0] = org_st_q;
			ADDR_ORG_MT: rdat_d[MT_W-1:0] = org_mt_q;
			ADDR_STATUS: rdat_d[7:0] = {o_limit_state, valid_q, o_homing_busy, o_warning,
				done_q, state_q};
			ADDR_IRQ_ST: rdat_d[IRQ_W-1:0] = irq_st_q;
			ADDR_IRQ_MASK: rdat_d[IRQ_W-1:0] = irq_mask_q;
			ADDR_CUR_POS: rdat_d = pos_diff[31:0];
			ADDR_ENC_CFG: rdat_d[0] = mtu_q;
			default: rdat_d = 32'h0000_0000;
		endcase
	end

	// bus and configuration registers
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			cfg_q <= CFG_RST;
			mode_q <= MODE_RST;
			mtu_q <= 1'b0;
			spd_tw_q <= SPD_TOWARD_RST;
			spd_lv_q <= SPD_LEAVE_RST;
			pin_st_q <= PIN_START_RST;
			pin_org_q <= PIN_ORG_RST;
			irq_st_q <= '0;
			irq_mask_q <= '0;
			rdat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			mode_q <= mode_d;
			mtu_q <= mtu_d;
			spd_tw_q <= spd_tw_d;
			spd_lv_q <= spd_lv_d;
			pin_st_q <= pin_st_d;
			pin_org_q <= pin_org_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			rdat_q <= rdat_d;
			ack_q <= ack_d;
		end
	end
	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign o_irq = |(irq_st_q & irq_mask_q);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	property p_disabled_stays;
		(state_q == ST_IDLE && !act_en && !boot) |=> (state_q == ST_IDLE);
	endproperty
	a_disabled_stays: assert property (p_disabled_stays) else $error("homing ran while off");
	property p_start_seek;
		(trig && start_ok && act_mode_q != 4'h0 && !boot) |=> (state_q == ST_SEEK) && o_move_enable;
	endproperty
	a_start_seek: assert property (p_start_seek) else $error("start edge did not seek");
	property p_refuse;
		(trig && !start_ok && !boot) |=> (state_q == ST_IDLE) ##1 (state_q == ST_IDLE || start_rise);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused start was kept");
	property p_alarm;
		i_multiturn_alarm |=> !o_homing_done && !valid_q && org_st_q == '0;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm left origin or done");
	property p_store;
		(finish && act_store && !boot && !i_multiturn_alarm) |=> valid_q
			&& org_st_q == $past(i_single_turn) && org_mt_q == $past(i_multi_turn);
	endproperty
	a_store: assert property (p_store) else $error("origin not stored");
	property p_nostore;
		(boot && !cfg_q[CFG_STORE_BIT]) |=> !valid_q && org_mt_q == '0;
	endproperty
	a_nostore: assert property (p_nostore) else $error("origin not cleared");
	property p_repower_done;
		(boot && cfg_q[CFG_EN_BIT] && cfg_q[CFG_STORE_BIT] && !mtu_q && valid_q
			&& !i_multiturn_alarm) |=> o_homing_done;
	endproperty
	a_repower_done: assert property (p_repower_done) else $error("no done at power-up");
	property p_warn;
		(i_multiturn_alarm && act_store && !boot) |=> o_warning;
	endproperty
	a_warn: assert property (p_warn) else $error("missing origin warning");
	property p_limit;
		(state_q == ST_SEEK && !decel_hit && limit_hit && act_limit && i_servo_on
			&& i_position_mode && !boot) |=> o_limit_state && !o_move_enable;
	endproperty
	a_limit: assert property (p_limit) else $error("limit state not entered");
	property p_backoff;
		(state_q == ST_SEEK && !decel_hit && limit_hit && !act_limit && i_servo_on
			&& i_position_mode && !boot) |=> (state_q == ST_BACKOFF) && (dir_q != $past(dir_q));
	endproperty
	a_backoff: assert property (p_backoff) else $error("no back-off at limit");
	property p_pos_mode;
		(!i_position_mode && state_q != ST_LIMIT) |=> !o_homing_busy;
	endproperty
	a_pos_mode: assert property (p_pos_mode) else $error("homing outside position mode");
	property p_positioning_complete_output_ot;
		(state_q == ST_IDLE && (!i_positioning_complete || i_forward_overtravel
			|| i_reverse_overtravel)) |=> !o_homing_busy;
	endproperty
	a_positioning_complete_output_ot: assert property (p_positioning_complete_output_ot) else $error("start taken when barred");
	property p_ref_block;
		o_homing_busy && i_pos_ref_valid |-> !o_position_ref_accept;
	endproperty
	a_ref_block: assert property (p_ref_block) else $error("reference passed while homing");
	property p_cfg_hold;
		!boot |=> $stable(act_cfg_q) && $stable(act_mode_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed before power-up");

	c_home_done: cover property (state_q == ST_CREEP ##[1:50] ev_done);
	c_backoff: cover property (state_q == ST_BACKOFF ##[1:50] state_q == ST_SEEK);
	c_limit: cover property (ev_limit);
	c_refused: cover property (ev_refused);
endmodule

//--- design/shm_pkg.sv
// shared constants and types for the servo homing and origin store block
package shm_pkg;
	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_SPEED = 8'h08;
	localparam logic [7:0] ADDR_PINSEL = 8'h0C;
	localparam logic [7:0] ADDR_ORG_ST = 8'h10;
	localparam logic [7:0] ADDR_ORG_MT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
	localparam logic [7:0] ADDR_CUR_POS = 8'h24;
	localparam logic [7:0] ADDR_ENC_CFG = 8'h28;

	// ---------------------------------------------------------------
	// field positions and widths
	// ---------------------------------------------------------------
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_AUTO_BIT = 4;
	localparam int CFG_STORE_BIT = 8;
	localparam int CFG_LIMIT_BIT = 12;
	localparam int SPD_LEAVE_LSB = 16;
	localparam int PIN_ORG_LSB = 4;
	localparam int ST_W = 24;
	localparam int MT_W = 16;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_LIMIT = 1;
	localparam int IRQ_WARN = 2;
	localparam int IRQ_REFUSED = 3;
	localparam int IRQ_W = 4;

	// ---------------------------------------------------------------
	// values after reset and limits
	// ---------------------------------------------------------------
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [3:0] MODE_MAX = 4'hA;
	localparam logic [11:0] SPD_TOWARD_RST = 12'h5DC;
	localparam logic [11:0] SPD_TOWARD_MAX = 12'hBB8;
	localparam logic [7:0] SPD_LEAVE_RST = 8'h1E;
	localparam logic [7:0] SPD_LEAVE_MAX = 8'hC8;
	localparam logic [2:0] PIN_START_RST = 3'h0;
	localparam logic [2:0] PIN_ORG_RST = 3'h1;

	typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_CREEP, ST_BACKOFF, ST_LIMIT} shm_state_e;
endpackage

//--- sim/shm_axis_model.sv
// far-side model: encoder, origin switch and index pulse of one axis
`timescale 1ns/1ps
module shm_axis_model
#(
	parameter logic [15:0] MT_START = 16'h0012
)
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_move_enable,
	input wire logic i_move_forward,
	input wire logic i_slow,
	input wire logic [shm_pkg::ST_W-1:0] i_org_at,
	output logic [shm_pkg::ST_W-1:0] o_single_turn,
	output logic [shm_pkg::MT_W-1:0] o_multi_turn,
	output logic o_org_pin,
	output logic o_index
);
	import shm_pkg::*;
	logic [ST_W-1:0] pos_q;
	logic [ST_W-1:0] pos_d;
	logic [1:0] div_q;
	logic [1:0] div_d;
	logic step;

	// one count per cycle, or one per four when slow
	always_comb
	begin
		div_d = div_q + 2'h1;
		step = i_move_enable && (!i_slow || div_q == 2'h3);
		pos_d = pos_q;
		if (step)
			pos_d = i_move_forward ? pos_q + 24'h1 : pos_q - 24'h1;
	end

	// position register; starts away from zero so a saved origin is visible
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			pos_q <= 24'h000100;
			div_q <= 2'h0;
		end
		else
		begin
			pos_q <= pos_d;
			div_q <= div_d;
		end
	end

	// switch is a 16-count wide cam; turns fixed, no wrap in these runs
	assign o_org_pin = (pos_q >= i_org_at) && (pos_q < i_org_at + 24'h10);
	assign o_index = (pos_q[7:0] == 8'h00);
	assign o_single_turn = pos_q;
	assign o_multi_turn = MT_START;
endmodule

//--- sim/shm_homing_tb.sv
// self-checking bench for the homing controller
`timescale 1ns/1ps
module shm_homing_tb;
	import shm_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic cyc = 0, stb = 0, we = 0, pwr_up = 0, start_pin = 0, servo = 1, pmode = 1;
	logic pcomp = 1, fot = 0, rot = 0, alarm = 0, refv = 0, slow = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat_q;
	logic [23:0] org_at = 24'h000140, st;
	wire [31:0] rdat;
	wire ack, mv_en, mv_fwd, busy, done, lim_st, warn, irq, ref_acc, org_pin, index;
	wire [11:0] mv_spd;
	wire [23:0] enc_st;
	wire [15:0] enc_mt;
	int err_count = 0;
	int compares = 0;

	// ---------------------------------------------------------------
	// clock, design and far side
	// ---------------------------------------------------------------
	always #10 clk = ~clk;

	shm_homing shm_homing_i (.i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_power_up(pwr_up), .i_input_pins({2'b00, org_pin, 2'b00, start_pin, 2'b00}),
		.i_servo_on(servo), .i_position_mode(pmode), .i_positioning_complete(pcomp),
		.i_forward_overtravel(fot), .i_reverse_overtravel(rot), .i_index_pulse(index),
		.i_single_turn(enc_st), .i_multi_turn(enc_mt), .i_multiturn_alarm(alarm),
		.i_pos_ref_valid(refv), .o_position_ref_accept(ref_acc), .o_move_enable(mv_en),
		.o_move_forward(mv_fwd), .o_move_speed(mv_spd), .o_homing_busy(busy),
		.o_homing_done(done), .o_limit_state(lim_st), .o_warning(warn), .o_irq(irq));

	shm_axis_model shm_axis_model_i (.i_clk_sys(clk), .i_reset(rst), .i_move_enable(mv_en),
		.i_move_forward(mv_fwd), .i_slow(slow), .i_org_at(org_at), .o_single_turn(enc_st),
		.o_multi_turn(enc_mt), .o_org_pin(org_pin), .o_index(index));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
		begin
			err_count++;
			test_done();
		end
		rdat_q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(0, a, 32'h0);
		check(rdat_q, exp);
	endtask

	task automatic pwr();
		pwr_up <= 1;
		@(posedge clk);
		pwr_up <= 0;
		repeat (2) @(posedge clk);
	endtask

	task automatic pulse_start();
		start_pin <= 1;
		repeat (3) @(posedge clk);
		start_pin <= 0;
		repeat (2) @(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		int n;
		repeat (20) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		rd(ADDR_SPEED, 32'h001E05DC);
		rd(ADDR_PINSEL, 32'h00000010);
		rd(8'h30, 32'h0);
		wb(1, ADDR_SPEED, 32'h00FF0FA0);
		rd(ADDR_SPEED, 32'h00C80BB8);
		wb(1, ADDR_PINSEL, 32'h00000052);
		wb(1, ADDR_IRQ_MASK, 32'h1);
		wb(1, ADDR_MODE, 32'h1);
		wb(1, ADDR_CFG, 32'h0101);
		pulse_start();
		check(busy, 0);
		pwr();
		check(warn, 1);
		fot <= 1;
		pulse_start();
		check(busy, 0);
		fot <= 0;
		repeat (2) @(posedge clk);
		check(busy, 0);
		pcomp <= 0;
		pulse_start();
		check(busy, 0);
		pcomp <= 1;
		pmode <= 0;
		pulse_start();
		check(busy, 0);
		pmode <= 1;
		wb(0, ADDR_IRQ_ST, 32'h0);
		check(rdat_q & 32'h8, 32'h8);
		check(irq, 0);
		// slow far side, origin switch on the remapped pin
		refv <= 1;
		slow <= 1;
		pulse_start();
		check(busy, 1);
		check(mv_fwd, 1);
		check(mv_spd, 12'hBB8);
		check(mv_en, 1);
		check(ref_acc, 0);
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		check(n < 3000, 1);
		if (n >= 3000)
			test_done();
		repeat (2) @(posedge clk);
		check(busy, 0);
		check(irq, 1);
		check(ref_acc, 1);
		check(warn, 0);
		rd(ADDR_STATUS, 32'h00000048);
		wb(0, ADDR_ORG_ST, 32'h0);
		st = rdat_q[23:0];
		check((enc_st - st) < 24'h2 || (st - enc_st) < 24'h2, 1);
		rd(ADDR_ORG_MT, 32'h0012);
		rd(ADDR_CUR_POS, {8'h0, enc_st} - {8'h0, st});
		wb(1, ADDR_IRQ_ST, 32'h1);
		@(posedge clk);
		check(irq, 0);
		// multi-turn data not in use: no done at power-up
		wb(1, ADDR_ENC_CFG, 32'h1);
		pwr();
		check(done, 0);
		wb(1, ADDR_ENC_CFG, 32'h0);
		pwr();
		check(done, 1);
		alarm <= 1;
		repeat (2) @(posedge clk);
		check(done, 0);
		check(warn, 1);
		rd(ADDR_ORG_ST, 32'h0);
		rd(ADDR_ORG_MT, 32'h0);
		alarm <= 0;
		slow <= 0;
		org_at <= 24'hFFFF00;
		// overtravel met during the forward search, both behaviours
		for (int lim = 0; lim < 2; lim++)
		begin
			wb(1, ADDR_CFG, 32'h0101 | (32'(lim) << 12));
			pwr();
			pulse_start();
			check(busy, 1);
			fot <= 1;
			repeat (3) @(posedge clk);
			check(lim_st, 32'(lim));
			if (lim == 0)
				check(mv_fwd, 0);
			fot <= 0;
			servo <= 0;
			repeat (3) @(posedge clk);
			check(busy, 0);
			servo <= 1;
			repeat (2) @(posedge clk);
		end
		// mode 10: reverse to the overtravel switch, then creep to the index
		wb(1, ADDR_MODE, 32'hA);
		pwr();
		pulse_start();
		check(mv_fwd, 0);
		rot <= 1;
		repeat (3) @(posedge clk);
		check(mv_fwd, 1);
		check(mv_spd, 12'h0C8);
		rot <= 0;
		n = 0;
		while (done !== 1'b1 && n < 600)
		begin
			@(posedge clk);
			n++;
		end
		check(n < 600, 1);
		if (n >= 600)
			test_done();
		wb(0, ADDR_ORG_ST, 32'h0);
		check(rdat_q[7:0], 8'h00);
		// alarm wipes the origin so the auto-home below must earn its done
		alarm <= 1;
		@(posedge clk);
		alarm <= 0;
		// mode 0 started by the first servo-on, then store switched off
		wb(1, ADDR_MODE, 32'h0);
		wb(1, ADDR_CFG, 32'h0111);
		servo <= 0;
		pwr();
		servo <= 1;
		repeat (3) @(posedge clk);
		check(done, 1);
		rd(ADDR_ORG_ST, {8'h0, enc_st});
		wb(1, ADDR_CFG, 32'h0011);
		pwr();
		rd(ADDR_ORG_ST, 32'h0);
		test_done();
	end
endmodule
